// File: logic/valve_pkg.sv
// Package: shared constants, types and register map of the valve actuator controller.
// Assumes a single 25 MHz clock; all long times are counted in millisecond ticks.
package valve_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   // Times in milliseconds
   localparam logic [15:0] TRAVEL_TIMEOUT_MS = 16'd30000;
   localparam logic [15:0] SHUTOFF_TIMEOUT_MS = 16'd3000;
   localparam logic [15:0] FAULT_PULSE_MS = 16'd2000;
   localparam logic [15:0] GREEN_BLINK_MS = 16'd500;
   localparam logic [15:0] LONG_ON_MS = 16'd1000;
   localparam logic [15:0] SHORT_ON_MS = 16'd250;
   localparam logic [15:0] GAP_MS = 16'd400;
   localparam logic [15:0] PAUSE_MS = 16'd2000;
   // Clean open/close cycles needed to clear a recorded fault
   localparam logic [1:0] CLEAN_CYCLES = 2'd2;
   // APB byte offsets
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] FAULT_OFS = 8'h08;
   localparam logic [7:0] LIMIT_OFS = 8'h0C;
   // Reset values
   localparam logic [6:0] STATUS_RST = 7'h00;
   localparam logic [6:0] MASK_RST = 7'h00;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   // Status bit positions
   localparam int ST_CLOSE_TO = 0;
   localparam int ST_CLOSE_STALL = 1;
   localparam int ST_SHUT_TO = 2;
   localparam int ST_OPEN_TO = 3;
   localparam int ST_OPEN_STALL = 4;
   localparam int ST_END_REACHED = 5;
   localparam int ST_FAULT_CLEARED = 6;

   typedef enum logic [2:0] {
      F_NONE = 3'b000,
      F_CLOSE_TO = 3'b001,
      F_CLOSE_STALL = 3'b010,
      F_SHUT_TO = 3'b011,
      F_OPEN_TO = 3'b100,
      F_OPEN_STALL = 3'b101
   } fault_t;

   typedef enum logic [2:0] {
      S_HOLD = 3'b000,
      S_OPENING = 3'b001,
      S_CLOSING = 3'b010,
      S_SEATING = 3'b011,
      S_FAULT = 3'b100
   } motion_t;

   // Configuration switches, position 1 to 4
   typedef struct packed {
      logic reserved;
      logic throttling;
      logic ball_valve;
      logic fail_open;
   } cfg_t;

   // Diagnostic blink code: long blinks then short blinks
   typedef struct packed {
      logic [1:0] longs;
      logic [1:0] shorts;
   } blink_code_t;
endpackage

// File: logic/diag_blinker.sv
// Diagnostic LED blinker: shows long blinks, then short blinks, then a pause.
// Assumes ms_tick is a one-cycle enable from the same clock; code is steady.
`timescale 1ns/1ps
`default_nettype none
module diag_blinker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Timing and code
   input wire logic ms_tick,
   input wire valve_pkg::blink_code_t code,
   // LED
   output logic led
);
   import valve_pkg::*;

   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_LONG = 3'b001,
      B_SHORT = 3'b010,
      B_GAP = 3'b011,
      B_PAUSE = 3'b100
   } blink_t;

   blink_t st_q, st_d;
   logic [15:0] ms_q;
   logic [1:0] longs_q, shorts_q;
   logic [1:0] longs_d, shorts_d;
   logic [15:0] span;
   wire blank = (code.longs == 2'd0) && (code.shorts == 2'd0);
   wire span_done = ms_tick && (ms_q >= span - 16'd1);

   always_comb begin
      case (st_q)
         B_LONG: span = LONG_ON_MS;
         B_SHORT: span = SHORT_ON_MS;
         B_GAP: span = GAP_MS;
         B_PAUSE: span = PAUSE_MS;
         default: span = 16'd1;
      endcase
   end

   always_comb begin
      st_d = st_q;
      longs_d = longs_q;
      shorts_d = shorts_q;
      case (st_q)
         B_IDLE: begin
            if (!blank) begin
               longs_d = code.longs;
               shorts_d = code.shorts;
               st_d = (code.longs != 2'd0) ? B_LONG : B_SHORT;
            end
         end
         B_LONG: begin
            if (span_done) begin
               longs_d = longs_q - 2'd1;
               st_d = B_GAP;
            end
         end
         B_SHORT: begin
            if (span_done) begin
               shorts_d = shorts_q - 2'd1;
               st_d = B_GAP;
            end
         end
         B_GAP: begin
            if (span_done) begin
               if (longs_q != 2'd0) begin
                  st_d = B_LONG;
               end else if (shorts_q != 2'd0) begin
                  st_d = B_SHORT;
               end else begin
                  st_d = B_PAUSE;
               end
            end
         end
         B_PAUSE: begin
            if (span_done) begin
               st_d = B_IDLE;
            end
         end
         default: st_d = B_IDLE;
      endcase
      // A code going blank ends the sequence at once
      if (blank) begin
         st_d = B_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= B_IDLE;
         ms_q <= 16'h0000;
         longs_q <= 2'd0;
         shorts_q <= 2'd0;
         led <= 1'b0;
      end else begin
         st_q <= st_d;
         longs_q <= longs_d;
         shorts_q <= shorts_d;
         ms_q <= (st_d != st_q) ? 16'h0000 : (ms_tick ? ms_q + 16'd1 : ms_q);
         led <= (st_d == B_LONG) || (st_d == B_SHORT);
      end
   end
endmodule
`default_nettype wire

// File: logic/valve_actuator_ctrl.sv
// Valve actuator controller: motion, fault supervision, LEDs, fault output, APB registers.
// Assumes asynchronous pins for command, limits, overcurrent and switches; APB on pclk.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module valve_actuator_ctrl #(
   parameter int unsigned MS_DIV = valve_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Field pins
   input wire logic command_input,
   input wire logic open_limit,
   input wire logic close_limit,
   input wire logic overcurrent,
   input wire valve_pkg::cfg_t cfg_sw,
   // Motor and current limit
   output logic motor_open,
   output logic motor_close,
   output logic close_limit_en,
   output logic [7:0] close_limit_da,
   // Indicators
   output logic fault_out,
   output logic red_led,
   output logic green_led,
   output logic diag_led
);
   import valve_pkg::*;

   // Two-stage synchronizers for all pins
   logic [7:0] sync1_q, sync2_q;
   wire [7:0] pins = {cfg_sw, overcurrent, close_limit, open_limit, command_input};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end
   wire cmd_s = sync2_q[0];
   wire open_lim_s = sync2_q[1];
   wire close_lim_s = sync2_q[2];
   wire oc_s = sync2_q[3];
   cfg_t cfg_s;
   assign cfg_s = sync2_q[7:4];
   // Reserved switch position drives no logic, only the fault register; the installer leaves it off.

   // Motion waits until the synchronizers hold real pin levels
   logic [1:0] warm_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_q <= 2'b00;
      end else begin
         warm_q <= {warm_q[0], 1'b1};
      end
   end
   wire live = warm_q[1];

   // Millisecond enable
   logic [$clog2(MS_DIV)-1:0] div_q;
   wire ms_tick = (div_q == ($clog2(MS_DIV))'(MS_DIV - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else begin
         div_q <= ms_tick ? '0 : div_q + 1'b1;
      end
   end

   // Target end: failsafe when command off, opposite when on
   logic force_fs_q;
   wire fs_open = cfg_s.fail_open;
   wire cmd_open = cmd_s ? !fs_open : fs_open;
   wire tgt_open = force_fs_q ? fs_open : cmd_open;

   // Motion state machine
   motion_t st_q, st_d;
   fault_t flt_d, cur_flt_q, last_flt_q;
   logic [15:0] ms_q;
   logic fault_tgt_q;
   wire tmo_travel = ms_tick && (ms_q >= TRAVEL_TIMEOUT_MS - 16'd1);
   wire tmo_shut = ms_tick && (ms_q >= SHUTOFF_TIMEOUT_MS - 16'd1);
   logic open_done, close_done;

   always_comb begin
      st_d = st_q;
      flt_d = F_NONE;
      open_done = 1'b0;
      close_done = 1'b0;
      case (st_q)
         S_HOLD: begin
            if (live && tgt_open && !open_lim_s) begin
               st_d = S_OPENING;
            end else if (live && !tgt_open && !close_lim_s) begin
               st_d = S_CLOSING;
            end
         end
         S_OPENING: begin
            if (!tgt_open) begin
               st_d = S_CLOSING;
            end else if (open_lim_s) begin
               st_d = S_HOLD;
               open_done = 1'b1;
            end else if (oc_s) begin
               flt_d = F_OPEN_STALL;
            end else if (tmo_travel) begin
               flt_d = F_OPEN_TO;
            end
         end
         S_CLOSING: begin
            if (tgt_open) begin
               st_d = S_OPENING;
            end else if (close_lim_s) begin
               // Only linear valves seat against torque
               st_d = cfg_s.ball_valve ? S_HOLD : S_SEATING;
               close_done = cfg_s.ball_valve;
            end else if (oc_s) begin
               flt_d = F_CLOSE_STALL;
            end else if (tmo_travel) begin
               flt_d = F_CLOSE_TO;
            end
         end
         S_SEATING: begin
            if (tgt_open) begin
               st_d = S_OPENING;
            end else if (oc_s) begin
               st_d = S_HOLD;
               close_done = 1'b1;
            end else if (tmo_shut) begin
               flt_d = F_SHUT_TO;
            end
         end
         S_FAULT: begin
            // Motor stays off until the target end changes
            if (tgt_open != fault_tgt_q) begin
               st_d = S_HOLD;
            end
         end
         default: st_d = S_HOLD;
      endcase
      if (flt_d != F_NONE) begin
         st_d = S_FAULT;
      end
   end
   wire new_fault = (flt_d != F_NONE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_HOLD;
         ms_q <= 16'h0000;
         fault_tgt_q <= 1'b0;
         cur_flt_q <= F_NONE;
      end else begin
         st_q <= st_d;
         ms_q <= (st_d != st_q) ? 16'h0000 : (ms_tick ? ms_q + 16'd1 : ms_q);
         if (new_fault) begin
            fault_tgt_q <= tgt_open;
            cur_flt_q <= flt_d;
         end else if (st_d != S_FAULT) begin
            cur_flt_q <= F_NONE;
         end
      end
   end

   // Dump mode retreats to failsafe after a fault met travelling away from failsafe; throttling holds in place
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_fs_q <= 1'b0;
      end else if (new_fault && !cfg_s.throttling && (tgt_open != fs_open)) begin
         force_fs_q <= 1'b1;
      end else if (cmd_open == fs_open) begin
         force_fs_q <= 1'b0;
      end
   end

   // Fault record, cleared by clean open and close cycles
   logic saw_open_q, saw_close_q;
   logic [1:0] clean_q;
   wire cycle_done = (saw_open_q || open_done) && (saw_close_q || close_done);
   wire clear_rec = cycle_done && (clean_q == CLEAN_CYCLES - 2'd1) && (last_flt_q != F_NONE);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_flt_q <= F_NONE;
         saw_open_q <= 1'b0;
         saw_close_q <= 1'b0;
         clean_q <= 2'd0;
      end else if (new_fault) begin
         last_flt_q <= flt_d;
         saw_open_q <= 1'b0;
         saw_close_q <= 1'b0;
         clean_q <= 2'd0;
      end else if (cycle_done) begin
         saw_open_q <= 1'b0;
         saw_close_q <= 1'b0;
         clean_q <= clear_rec ? 2'd0 : clean_q + 2'd1;
         if (clear_rec) begin
            last_flt_q <= F_NONE;
         end
      end else begin
         saw_open_q <= saw_open_q || open_done;
         saw_close_q <= saw_close_q || close_done;
      end
   end

   // Fault output, normally on, off for a fixed time per fault
   logic [15:0] pulse_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 16'h0000;
         fault_out <= 1'b1;
      end else begin
         if (new_fault) begin
            pulse_q <= FAULT_PULSE_MS;
         end else if (ms_tick && pulse_q != 16'h0000) begin
            pulse_q <= pulse_q - 16'd1;
         end
         fault_out <= !(new_fault || (pulse_q != 16'h0000));
      end
   end

   // Indicators
   logic [15:0] gms_q;
   logic gblink_q;
   wire moving = (st_q == S_OPENING) || (st_q == S_CLOSING) || (st_q == S_SEATING);
   wire at_end = (st_q == S_HOLD) && (tgt_open ? open_lim_s : close_lim_s);
   wire red_d = (last_flt_q != F_NONE) && (cur_flt_q == F_NONE);
   fault_t shown_flt;
   assign shown_flt = red_d ? last_flt_q : cur_flt_q;
   blink_code_t code;
   always_comb begin
      case (shown_flt)
         F_CLOSE_TO: code = '{longs: 2'd1, shorts: 2'd1};
         F_CLOSE_STALL: code = '{longs: 2'd1, shorts: 2'd2};
         F_SHUT_TO: code = '{longs: 2'd1, shorts: 2'd3};
         F_OPEN_TO: code = '{longs: 2'd2, shorts: 2'd1};
         F_OPEN_STALL: code = '{longs: 2'd2, shorts: 2'd2};
         default: code = '{longs: 2'd0, shorts: 2'd0};
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gms_q <= 16'h0000;
         gblink_q <= 1'b0;
         green_led <= 1'b0;
         red_led <= 1'b0;
         motor_open <= 1'b0;
         motor_close <= 1'b0;
      end else begin
         if (ms_tick) begin
            gms_q <= (gms_q >= GREEN_BLINK_MS - 16'd1) ? 16'h0000 : gms_q + 16'd1;
            gblink_q <= (gms_q >= GREEN_BLINK_MS - 16'd1) ? !gblink_q : gblink_q;
         end
         green_led <= moving ? gblink_q : at_end;
         red_led <= red_d;
         motor_open <= (st_d == S_OPENING);
         motor_close <= (st_d == S_CLOSING) || (st_d == S_SEATING);
      end
   end

   diag_blinker u_blink (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick),
      .code(code),
      .led(diag_led)
   );

   // APB registers, zero wait state
   logic [6:0] status_q, mask_q;
   logic [7:0] limit_q;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_st = (paddr == STATUS_OFS);
   wire hit_mask = (paddr == MASK_OFS);
   wire hit_flt = (paddr == FAULT_OFS);
   wire hit_lim = (paddr == LIMIT_OFS);
   wire mapped = hit_st || hit_mask || hit_flt || hit_lim;
   wire [6:0] events = {clear_rec, open_done || close_done, flt_d == F_OPEN_STALL,
      flt_d == F_OPEN_TO, flt_d == F_SHUT_TO, flt_d == F_CLOSE_STALL, flt_d == F_CLOSE_TO};
   wire [31:0] flt_word = {14'h0000, clean_q, cfg_s, 1'b0, st_q,
      1'b0, last_flt_q, 1'b0, cur_flt_q};
   wire [31:0] rd_mux = hit_st ? {25'h0, status_q} :
      hit_mask ? {25'h0, mask_q} :
      hit_flt ? flt_word :
      hit_lim ? {24'h0, limit_q} : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= STATUS_RST;
         mask_q <= MASK_RST;
         limit_q <= LIMIT_RST;
         prdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         // New events win over the read that clears
         status_q <= ((rd && hit_st) ? 7'h00 : status_q) | events;
         if (wr && hit_mask) begin
            mask_q <= pwdata[6:0];
         end
         if (wr && hit_lim) begin
            limit_q <= pwdata[7:0];
         end
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
         irq <= |(status_q & mask_q);
      end
   end

   // Current limit only for linear valves, in every motion state; zero means no limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         close_limit_en <= 1'b0;
         close_limit_da <= 8'h00;
      end else begin
         close_limit_en <= !cfg_s.ball_valve && (limit_q != 8'h00);
         close_limit_da <= limit_q;
      end
   end
endmodule
`default_nettype wire

// File: dv/valve_checker.sv
// Checker: port-level properties of the valve actuator controller.
// Assumes it is bound into valve_actuator_ctrl with the same MS_DIV.
`timescale 1ns/1ps
`default_nettype none
module valve_checker #(
   parameter int unsigned MS_DIV = 25000
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Field pins
   input wire logic command_input,
   input wire logic open_limit,
   input wire logic close_limit,
   input wire logic overcurrent,
   input wire valve_pkg::cfg_t cfg_sw,
   // Outputs
   input wire logic motor_open,
   input wire logic motor_close,
   input wire logic close_limit_en,
   input wire logic [7:0] close_limit_da,
   input wire logic fault_out
);
   import valve_pkg::*;
   // Tick phase adds up to one tick of slack
   localparam int LO_MIN = (int'(FAULT_PULSE_MS) - 1) * MS_DIV;
   localparam int LO_MAX = (int'(FAULT_PULSE_MS) + 2) * MS_DIV;
   int lo_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_cnt_q <= 0;
      else lo_cnt_q <= fault_out ? 0 : lo_cnt_q + 1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_excl;
      !(motor_open && motor_close);
   endproperty
   a_excl: assert property (p_excl) else $error("both motor drives on");
   property p_dir;
      ($stable(command_input) && $stable(cfg_sw))[*5] ##0 !command_input
         |-> !((motor_open && !cfg_sw.fail_open) || (motor_close && cfg_sw.fail_open));
   endproperty
   a_dir: assert property (p_dir) else $error("drive toward wrong end");
   property p_open_stop;
      open_limit[*2] |-> ##[0:4] !motor_open;
   endproperty
   a_open_stop: assert property (p_open_stop) else $error("open drive past limit");
   property p_close_stop;
      (close_limit && cfg_sw.ball_valve)[*2] |-> ##[0:4] !motor_close;
   endproperty
   a_close_stop: assert property (p_close_stop) else $error("close drive past limit");
   property p_stall_stop;
      (overcurrent && motor_open)[*2] |-> ##[0:4] !motor_open;
   endproperty
   a_stall_stop: assert property (p_stall_stop) else $error("motor kept on in stall");
   property p_stall_fault;
      (overcurrent && motor_open)[*2] |-> ##[0:4] !fault_out;
   endproperty
   a_stall_fault: assert property (p_stall_fault) else $error("stall not reported");
   property p_pulse;
      $rose(fault_out) |-> lo_cnt_q >= LO_MIN && lo_cnt_q <= LO_MAX;
   endproperty
   a_pulse: assert property (p_pulse) else $error("fault pulse length wrong");
   property p_climit;
      close_limit_en |-> close_limit_da != 8'h00 && !$past(cfg_sw.ball_valve, 3);
   endproperty
   a_climit: assert property (p_climit) else $error("limit enabled at zero");
   c_stop: cover property (motor_open ##1 !motor_open);
   c_fault: cover property ($fell(fault_out));
   c_climit: cover property (close_limit_en);
endmodule
bind valve_actuator_ctrl valve_checker #(.MS_DIV(MS_DIV)) i_valve_checker (.pclk, .presetn,
   .command_input, .open_limit, .close_limit, .overcurrent, .cfg_sw, .motor_open,
   .motor_close, .close_limit_en, .close_limit_da, .fault_out);
`default_nettype wire

// File: dv/valve_actuator_model.sv
// Actuator model: position counter with limit switches and a current flag.
// Assumes motor drives are levels from the controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module valve_actuator_model #(
   parameter int TRAVEL = 50
) (
   // Clock and motor
   input wire logic pclk,
   input wire logic motor_open,
   input wire logic motor_close,
   // Fault injection
   input wire logic stuck,
   input wire logic stall_req,
   input wire logic seat_ok,
   // Feedback
   output logic open_limit,
   output logic close_limit,
   output logic overcurrent
);
   int pos_q = 0;
   int seat_q = 0;
   always_ff @(posedge pclk) begin
      if (motor_open && !stuck && pos_q < TRAVEL) pos_q <= pos_q + 1;
      else if (motor_close && !stuck && pos_q > 0) pos_q <= pos_q - 1;
      seat_q <= (motor_close && pos_q == 0) ? seat_q + 1 : 0;
   end
   assign open_limit = (pos_q == TRAVEL);
   assign close_limit = (pos_q == 0);
   // Seat torque comes late so a ball valve stops before it trips
   assign overcurrent = (stall_req && (motor_open || motor_close)) || (seat_ok && seat_q >= 8);
endmodule
`default_nettype wire

// File: dv/test_quarter_turn_valve_actuator_ctrl.sv
// Testbench: drives field pins and APB, checks motion, faults and registers.
// Assumes the actuator model stands on the motor side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITFOR(c, lim) begin n = 0; while (!(c)) begin @(negedge pclk); n++; \
   if (n > (lim)) begin bad_count++; give_verdict; end end end
module test_quarter_turn_valve_actuator_ctrl;
   import valve_pkg::*;
   localparam int unsigned DIV = 2;
   localparam int SHORT_LO = (int'(SHORT_ON_MS) - 1) * DIV;
   localparam int SHORT_HI = (int'(SHORT_ON_MS) + 1) * DIV;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   logic command_input = 1'b0;
   logic stuck = 1'b0;
   logic stall_req = 1'b0;
   logic seat_ok = 1'b1;
   logic open_limit, close_limit, overcurrent, motor_open, motor_close;
   logic close_limit_en, fault_out, red_led, green_led, diag_led;
   logic [7:0] close_limit_da;
   cfg_t cfg_sw = 4'h2;
   int bad_count = 0;
   int checked = 0;
   int n;
   always #20 pclk = ~pclk;
   valve_actuator_ctrl #(.MS_DIV(DIV)) i_valve_actuator_ctrl (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .command_input,
      .open_limit, .close_limit, .overcurrent, .cfg_sw, .motor_open, .motor_close,
      .close_limit_en, .close_limit_da, .fault_out, .red_led, .green_led, .diag_led);
   valve_actuator_model i_valve_actuator_model (.pclk, .motor_open, .motor_close, .stuck,
      .stall_req, .seat_ok, .open_limit, .close_limit, .overcurrent);
   task give_verdict;
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            bad_count++;
            give_verdict;
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // Length of the next lit span of the diagnostic LED, left in n
   task lit_span;
      `WAITFOR(diag_led === 1'b1, 6000)
      n = 0;
      while (diag_led === 1'b1 && n < 6000) begin
         @(negedge pclk);
         n++;
      end
   endtask
   task move(input logic c, input logic up);
      @(posedge pclk);
      command_input <= c;
      `WAITFOR((up ? open_limit : close_limit) && !motor_open && !motor_close, 400)
      repeat (6) @(negedge pclk);
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_reg(MASK_OFS);
      `CHK(rd, 32'h0)
      rd_reg(LIMIT_OFS);
      `CHK(rd, 32'h0)
      rd_reg(8'h10);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, MASK_OFS, 32'h20);
      move(1'b1, 1'b1);
      `CHK({green_led, irq}, 2'h3)
      rd_reg(STATUS_OFS);
      `CHK(rd, 32'h20)
      repeat (3) @(negedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, MASK_OFS, 32'h0);
      move(1'b0, 1'b0);
      `CHK(irq, 1'b0)
      rd_reg(STATUS_OFS);
      `CHK(rd, 32'h20)
      apb(1'b1, MASK_OFS, 32'h7F);
      @(posedge pclk);
      command_input <= 1'b1;
      `WAITFOR(motor_open, 20)
      // Mid-travel trip, released once reported
      repeat (10) @(posedge pclk);
      stall_req <= 1'b1;
      `WAITFOR(!fault_out, 20)
      @(posedge pclk);
      stall_req <= 1'b0;
      `WAITFOR(fault_out, 5000)
      `CHK(n >= (1999 * DIV) && irq, 1'b1)
      rd_reg(STATUS_OFS);
      `CHK(rd & 32'h1F, 32'h10)
      rd_reg(FAULT_OFS);
      `CHK(rd & 32'h70, 32'h50)
      move(1'b0, 1'b0);
      move(1'b1, 1'b1);
      `CHK(red_led, 1'b1)
      rd_reg(STATUS_OFS);
      repeat (2) begin
         move(1'b0, 1'b0);
         move(1'b1, 1'b1);
      end
      rd_reg(STATUS_OFS);
      `CHK({rd & 32'h40, red_led}, {32'h40, 1'b0})
      @(posedge pclk);
      cfg_sw.ball_valve <= 1'b0;
      apb(1'b1, LIMIT_OFS, 32'h2A);
      repeat (5) @(negedge pclk);
      `CHK({close_limit_en, close_limit_da}, 9'h12A)
      apb(1'b1, LIMIT_OFS, 32'h0);
      repeat (5) @(negedge pclk);
      `CHK(close_limit_en, 1'b0)
      @(posedge pclk);
      seat_ok <= 1'b0;
      command_input <= 1'b0;
      `WAITFOR(!fault_out, 3000 * DIV + 400)
      rd_reg(STATUS_OFS);
      `CHK(rd & 32'h1F, 32'h04)
      rd_reg(FAULT_OFS);
      `CHK(rd & 32'h07, 32'h03)
      lit_span;
      `CHK(n > SHORT_HI, 1'b1)
      lit_span;
      `CHK(n >= SHORT_LO && n <= SHORT_HI, 1'b1)
      `WAITFOR(fault_out, 5000)
      @(posedge pclk);
      seat_ok <= 1'b1;
      cfg_sw.ball_valve <= 1'b1;
      move(1'b1, 1'b1);
      @(posedge pclk);
      stuck <= 1'b1;
      command_input <= 1'b0;
      `WAITFOR(!fault_out, 30000 * DIV + 500)
      rd_reg(STATUS_OFS);
      `CHK(rd & 32'h1F, 32'h01)
      rd_reg(FAULT_OFS);
      `CHK(rd & 32'h07, 32'h01)
      `WAITFOR(fault_out, 5000)
      @(posedge pclk);
      stuck <= 1'b0;
      cfg_sw.fail_open <= 1'b1;
      move(1'b1, 1'b0);
      `CHK(close_limit, 1'b1)
      move(1'b0, 1'b1);
      // Throttling: a close stall leaves the valve where it stopped
      @(posedge pclk);
      cfg_sw.throttling <= 1'b1;
      command_input <= 1'b1;
      `WAITFOR(motor_close, 20)
      repeat (10) @(posedge pclk);
      stall_req <= 1'b1;
      `WAITFOR(!fault_out, 20)
      @(posedge pclk);
      stall_req <= 1'b0;
      repeat (20) @(negedge pclk);
      rd_reg(STATUS_OFS);
      `CHK(rd & 32'h1F, 32'h02)
      rd_reg(FAULT_OFS);
      `CHK(rd & 32'h707, 32'h402)
      `CHK({motor_open, motor_close, open_limit, close_limit}, 4'h0)
      give_verdict;
   end
endmodule
`default_nettype wire
